// >>> hdl/line_shading_pkg.sv
// Constants, register map and sequencer states of the shading stage.
// Assumes a 40 MHz pixel clock and a word-wide external flash port.
package line_shading_pkg;
  // Geometry and arithmetic widths
  localparam int PIXELS = 2048;
  localparam int IDX_W = 11;
  localparam int PIX_W = 12;
  localparam int FACT_W = 16;
  localparam int FACT_FRAC = 12;
  localparam int GAIN_FRAC = 10;
  localparam int CHANNELS = 6;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 13;
  // Full-scale codes per resolution
  localparam logic [11:0] FULL_8 = 12'h0FF;
  localparam logic [11:0] FULL_12 = 12'hFFF;
  localparam logic [18:0] PERCENT = 19'h00064;
  // Flash layout: reference words at 0..PIXELS-1, enable word after
  localparam logic [11:0] FLASH_EN_ADDR = 12'h800;
  // Divider: dividend bits walked per factor, last step index
  localparam logic [4:0] DIV_LAST = 5'h17;
  // APB byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CMD_OFF = 8'h04;
  localparam logic [7:0] MIN_OFF = 8'h08;
  localparam logic [7:0] TARGET_OFF = 8'h0C;
  localparam logic [7:0] STATUS_OFF = 8'h10;
  localparam logic [7:0] LOADDATA_OFF = 8'h14;
  localparam logic [7:0] LOADPTR_OFF = 8'h18;
  localparam logic [7:0] GAIN_BASE = 8'h20;
  localparam logic [7:0] OFFSET_BASE = 8'h40;
  // Field positions
  localparam int CTRL_RES12_BIT = 0;
  localparam int CTRL_COUPLED_BIT = 1;
  localparam int CMD_ON_BIT = 0;
  localparam int CMD_OFF_BIT = 1;
  localparam int CMD_CAPTURE_BIT = 2;
  localparam int CMD_SAVE_BIT = 3;
  localparam int CMD_LOAD_BIT = 4;
  localparam int STAT_EN_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  // Reset values
  localparam logic [11:0] GAIN_RST = 12'h400;
  localparam logic [11:0] OFFSET_RST = 12'h000;
  localparam logic [6:0] MIN_PCT_RST = 7'h0A;
  localparam logic [6:0] TARGET_PCT_RST = 7'h5A;

  typedef enum logic [2:0] {
    ST_RESTORE_EN, ST_RESTORE, ST_IDLE, ST_CAPTURE,
    ST_LOAD, ST_DIVIDE, ST_SAVE, ST_SAVE_EN
  } seq_state_type;
endpackage

// >>> hdl/pixel_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic clk, // Pixel clock
  input wire logic reset, // Synchronous reset
  input wire logic inValid, // Word offered
  output logic inReady, // Room for a word
  input wire logic [WIDTH-1:0] inData, // Word written
  output logic outValid, // Word available
  input wire logic outReady, // Drain accepts
  output logic [WIDTH-1:0] outData // Oldest word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_type;

  fifo_state_type st_r;
  fifo_state_type st_nxt;
  logic push;
  logic pop;

  // Full and empty come straight from the fill count
  assign inReady = st_r.cnt != (AW+1)'(DEPTH);
  assign outValid = st_r.cnt != '0;
  assign outData = st_r.mem[st_r.rp];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Pointers wrap at DEPTH, which is a power of two here
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = inData;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// >>> hdl/line_shading_correction.sv
// Per-channel gain/offset and per-pixel shading correction of a line.
// Assumes an APB master, a word flash that acks each request, and a
// pixel stream with a line-start mark on the first pixel of each line.
`timescale 1ns/1ps
module line_shading_correction (
  input wire logic clk, // Pixel clock, 40 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic inValid, // Pixel offered
  output logic inReady, // Pixel taken
  input wire logic [11:0] inData, // Raw pixel code
  input wire logic [2:0] inChannel, // Video channel of pixel
  input wire logic inLineStart, // First pixel of a line
  output logic outValid, // Corrected pixel available
  input wire logic outReady, // Link accepts pixel
  output logic [11:0] outData, // Corrected pixel code
  output logic outLineStart, // First pixel of a line
  output logic flashReq, // Flash request, held to ack
  output logic flashWrite, // Flash request is a write
  output logic [11:0] flashAddr, // Flash word address
  output logic [11:0] flashWData, // Flash write word
  input wire logic [11:0] flashRData, // Flash read word
  input wire logic flashAck // Flash done, one cycle
);
  typedef struct packed {
    logic [line_shading_pkg::PIXELS-1:0][11:0] refMem;
    logic [line_shading_pkg::PIXELS-1:0][15:0] factMem;
    logic [line_shading_pkg::CHANNELS-1:0][11:0] gain;
    logic [line_shading_pkg::CHANNELS-1:0][11:0] offset;
    logic res12;
    logic coupled;
    logic [6:0] minPct;
    logic [6:0] tgtPct;
    logic enable;
    logic factValid;
    logic pendEn;
    line_shading_pkg::seq_state_type state;
    logic [10:0] ptr;
    logic [4:0] divCnt;
    logic [12:0] rem;
    logic [23:0] quo;
    logic [10:0] pixIdx;
    logic flashReq;
    logic flashWrite;
    logic [11:0] flashAddr;
    logic [11:0] flashWData;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } core_state_type;

  core_state_type st_r;
  core_state_type st_nxt;
  logic [line_shading_pkg::CHANNELS-1:0] gainHit;
  logic [line_shading_pkg::CHANNELS-1:0] offHit;
  logic fifoReady;
  logic [12:0] fifoIn;

  // Per-channel register address match
  genvar g;
  generate
    for (g = 0; g < line_shading_pkg::CHANNELS; g++) begin : chDecode
      assign gainHit[g] = paddr == 8'(line_shading_pkg::GAIN_BASE + 4*g);
      assign offHit[g] = paddr == 8'(line_shading_pkg::OFFSET_BASE + 4*g);
    end
  endgenerate

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign flashReq = st_r.flashReq;
  assign flashWrite = st_r.flashWrite;
  assign flashAddr = st_r.flashAddr;
  assign flashWData = st_r.flashWData;
  // Back-pressure from the link stalls the pixel source only once the 16-word output FIFO is full
  assign inReady = fifoReady;

  // Whole block: bus slave, sequencer, divider and pixel path
  always_comb begin
    logic wrEn;
    logic accept;
    logic [2:0] ch;
    logic [11:0] full;
    logic [11:0] minLevel;
    logic [11:0] tgtLevel;
    logic [18:0] pctProd;
    logic [23:0] gProd;
    logic signed [16:0] gSum;
    logic [11:0] gOut;
    logic [27:0] sProd;
    logic [11:0] pix;
    logic [10:0] idx;
    logic [23:0] dividend;
    logic [12:0] remS;
    logic [23:0] quoS;
    logic [4:0] bitSel;
    logic [31:0] rd;
    logic err;
    logic corrOn;
    logic cmdOk;
    wrEn = 1'b0;
    accept = 1'b0;
    ch = '0;
    full = '0;
    minLevel = '0;
    tgtLevel = '0;
    pctProd = '0;
    gProd = '0;
    gSum = '0;
    gOut = '0;
    sProd = '0;
    pix = '0;
    idx = '0;
    dividend = '0;
    remS = '0;
    quoS = '0;
    bitSel = '0;
    rd = '0;
    err = 1'b0;
    corrOn = 1'b0;
    cmdOk = 1'b0;
    st_nxt = st_r;

    // Levels derived from the percentage settings
    full = st_r.res12 ? line_shading_pkg::FULL_12 : line_shading_pkg::FULL_8;
    pctProd = 19'(st_r.minPct) * 19'(full);
    minLevel = 12'(pctProd / line_shading_pkg::PERCENT);
    pctProd = 19'(st_r.tgtPct) * 19'(full);
    tgtLevel = 12'(pctProd / line_shading_pkg::PERCENT);

    // APB: one wait state so read data comes from a flop
    st_nxt.pready = psel && penable && !st_r.pready;
    wrEn = psel && penable && st_r.pready && pwrite;
    case (paddr)
      line_shading_pkg::CTRL_OFF: begin
        rd[line_shading_pkg::CTRL_RES12_BIT] = st_r.res12;
        rd[line_shading_pkg::CTRL_COUPLED_BIT] = st_r.coupled;
      end
      line_shading_pkg::CMD_OFF: rd = '0;
      line_shading_pkg::MIN_OFF: rd = {25'h0000000, st_r.minPct};
      line_shading_pkg::TARGET_OFF: rd = {25'h0000000, st_r.tgtPct};
      line_shading_pkg::STATUS_OFF: begin
        rd[line_shading_pkg::STAT_EN_BIT] = st_r.enable;
        rd[line_shading_pkg::STAT_VALID_BIT] = st_r.factValid;
        rd[line_shading_pkg::STAT_BUSY_BIT] =
          st_r.state != line_shading_pkg::ST_IDLE;
      end
      line_shading_pkg::LOADDATA_OFF: rd = '0;
      line_shading_pkg::LOADPTR_OFF: rd = {21'h000000, st_r.ptr};
      default: err = !(|gainHit || |offHit);
    endcase
    for (int c = 0; c < line_shading_pkg::CHANNELS; c++) begin
      if (gainHit[c]) begin
        rd = {20'h00000, st_r.gain[c]};
      end
      if (offHit[c]) begin
        rd = {20'h00000, st_r.offset[c]};
      end
    end
    if (st_nxt.pready) begin
      st_nxt.prdata = pwrite ? 32'h00000000 : rd;
      st_nxt.pslverr = err;
    end else begin
      st_nxt.pslverr = 1'b0;
    end

    // Plain register writes take effect on the ready edge
    if (wrEn) begin
      case (paddr)
        line_shading_pkg::CTRL_OFF: begin
          st_nxt.res12 = pwdata[line_shading_pkg::CTRL_RES12_BIT];
          st_nxt.coupled = pwdata[line_shading_pkg::CTRL_COUPLED_BIT];
        end
        line_shading_pkg::MIN_OFF: st_nxt.minPct = pwdata[6:0];
        line_shading_pkg::TARGET_OFF: st_nxt.tgtPct = pwdata[6:0];
        default: ;
      endcase
      for (int c = 0; c < line_shading_pkg::CHANNELS; c++) begin
        if (gainHit[c]) begin
          st_nxt.gain[c] = pwdata[11:0];
        end
        if (offHit[c]) begin
          st_nxt.offset[c] = pwdata[11:0];
        end
      end
    end

    // Pixel path: gain/offset, then shading, then saturation
    accept = inValid && fifoReady;
    idx = inLineStart ? 11'h000 : st_r.pixIdx;
    ch = (st_r.coupled || inChannel >= 3'(line_shading_pkg::CHANNELS)) ?
      3'h0 : inChannel;
    gProd = 24'(inData) * 24'(st_r.gain[ch]);
    gSum = $signed({3'b000, gProd[23:line_shading_pkg::GAIN_FRAC]}) +
      17'($signed(st_r.offset[ch]));
    if (gSum < 0) begin
      gOut = '0;
    end else if (gSum > $signed({5'b00000, full})) begin
      gOut = full;
    end else begin
      gOut = gSum[11:0];
    end
    corrOn = st_r.enable && st_r.factValid &&
      st_r.state != line_shading_pkg::ST_CAPTURE;
    pix = gOut;
    if (corrOn && gOut >= minLevel) begin
      sProd = 28'(gOut) * 28'(st_r.factMem[idx]);
      if (sProd[27:line_shading_pkg::FACT_FRAC] > 16'(full)) begin
        pix = full;
      end else begin
        pix = sProd[23:line_shading_pkg::FACT_FRAC];
      end
    end
    if (accept) begin
      st_nxt.pixIdx = idx + 1'b1;
    end

    // Flash handshake: request drops for a cycle after each ack
    if (st_r.flashReq && flashAck) begin
      st_nxt.flashReq = 1'b0;
    end

    // Commands are taken only while the sequencer is idle
    cmdOk = wrEn && paddr == line_shading_pkg::CMD_OFF &&
      st_r.state == line_shading_pkg::ST_IDLE;
    dividend = {tgtLevel, 12'h000};
    bitSel = line_shading_pkg::DIV_LAST - st_r.divCnt;
    case (st_r.state)
      line_shading_pkg::ST_RESTORE_EN: begin
        if (!st_r.flashReq) begin
          st_nxt.flashReq = 1'b1;
          st_nxt.flashWrite = 1'b0;
          st_nxt.flashAddr = line_shading_pkg::FLASH_EN_ADDR;
        end else if (flashAck) begin
          st_nxt.enable = flashRData[0];
          st_nxt.ptr = '0;
          st_nxt.state = line_shading_pkg::ST_RESTORE;
        end
      end
      line_shading_pkg::ST_RESTORE: begin
        if (!st_r.flashReq) begin
          st_nxt.flashReq = 1'b1;
          st_nxt.flashWrite = 1'b0;
          st_nxt.flashAddr = {1'b0, st_r.ptr};
        end else if (flashAck) begin
          st_nxt.refMem[st_r.ptr] = flashRData;
          st_nxt.ptr = st_r.ptr + 1'b1;
          if (st_r.ptr == 11'(line_shading_pkg::PIXELS - 1)) begin
            st_nxt.pendEn = 1'b0;
            st_nxt.state = line_shading_pkg::ST_DIVIDE;
          end
        end
      end
      line_shading_pkg::ST_IDLE: begin
        st_nxt.ptr = '0;
        st_nxt.divCnt = '0;
        st_nxt.rem = '0;
        st_nxt.quo = '0;
        if (cmdOk && pwdata[line_shading_pkg::CMD_ON_BIT]) begin
          st_nxt.enable = 1'b1;
          st_nxt.state = line_shading_pkg::ST_SAVE_EN;
        end else if (cmdOk && pwdata[line_shading_pkg::CMD_OFF_BIT]) begin
          st_nxt.enable = 1'b0;
          st_nxt.state = line_shading_pkg::ST_SAVE_EN;
        end else if (cmdOk && pwdata[line_shading_pkg::CMD_CAPTURE_BIT]) begin
          st_nxt.state = line_shading_pkg::ST_CAPTURE;
        end else if (cmdOk && pwdata[line_shading_pkg::CMD_SAVE_BIT]) begin
          st_nxt.state = line_shading_pkg::ST_SAVE;
        end else if (cmdOk && pwdata[line_shading_pkg::CMD_LOAD_BIT]) begin
          st_nxt.state = line_shading_pkg::ST_LOAD;
        end
      end
      line_shading_pkg::ST_CAPTURE: begin
        // A line start restarts the capture, so short lines never count
        if (accept && (inLineStart || st_r.ptr != '0)) begin
          st_nxt.refMem[idx] = gOut;
          st_nxt.ptr = idx + 1'b1;
          if (idx == 11'(line_shading_pkg::PIXELS - 1)) begin
            st_nxt.ptr = '0;
            st_nxt.pendEn = 1'b0;
            st_nxt.state = line_shading_pkg::ST_DIVIDE;
          end
        end
      end
      line_shading_pkg::ST_LOAD: begin
        if (wrEn && paddr == line_shading_pkg::LOADDATA_OFF) begin
          st_nxt.refMem[st_r.ptr] = pwdata[11:0];
          st_nxt.ptr = st_r.ptr + 1'b1;
          if (st_r.ptr == 11'(line_shading_pkg::PIXELS - 1)) begin
            st_nxt.enable = 1'b1;
            st_nxt.pendEn = 1'b1;
            st_nxt.state = line_shading_pkg::ST_DIVIDE;
          end
        end
      end
      line_shading_pkg::ST_DIVIDE: begin
        // Restoring divider, one quotient bit per cycle
        st_nxt.factValid = 1'b0;
        remS = {st_r.rem[11:0], dividend[bitSel]};
        quoS = {st_r.quo[22:0], 1'b0};
        if (remS >= {1'b0, st_r.refMem[st_r.ptr]}) begin
          remS = remS - {1'b0, st_r.refMem[st_r.ptr]};
          quoS[0] = 1'b1;
        end
        st_nxt.rem = remS;
        st_nxt.quo = quoS;
        st_nxt.divCnt = st_r.divCnt + 1'b1;
        if (st_r.divCnt == line_shading_pkg::DIV_LAST) begin
          // Dark reference pixels get the largest factor, not a wrap
          st_nxt.factMem[st_r.ptr] = (|quoS[23:16]) ? 16'hFFFF :
            quoS[15:0];
          st_nxt.divCnt = '0;
          st_nxt.rem = '0;
          st_nxt.quo = '0;
          st_nxt.ptr = st_r.ptr + 1'b1;
          if (st_r.ptr == 11'(line_shading_pkg::PIXELS - 1)) begin
            st_nxt.factValid = 1'b1;
            st_nxt.state = st_r.pendEn ? line_shading_pkg::ST_SAVE_EN :
              line_shading_pkg::ST_IDLE;
          end
        end
      end
      line_shading_pkg::ST_SAVE: begin
        if (!st_r.flashReq) begin
          st_nxt.flashReq = 1'b1;
          st_nxt.flashWrite = 1'b1;
          st_nxt.flashAddr = {1'b0, st_r.ptr};
          st_nxt.flashWData = st_r.refMem[st_r.ptr];
        end else if (flashAck) begin
          st_nxt.ptr = st_r.ptr + 1'b1;
          if (st_r.ptr == 11'(line_shading_pkg::PIXELS - 1)) begin
            st_nxt.state = line_shading_pkg::ST_SAVE_EN;
          end
        end
      end
      line_shading_pkg::ST_SAVE_EN: begin
        if (!st_r.flashReq) begin
          st_nxt.flashReq = 1'b1;
          st_nxt.flashWrite = 1'b1;
          st_nxt.flashAddr = line_shading_pkg::FLASH_EN_ADDR;
          st_nxt.flashWData = {11'h000, st_r.enable};
        end else if (flashAck) begin
          st_nxt.pendEn = 1'b0;
          st_nxt.state = line_shading_pkg::ST_IDLE;
        end
      end
      default: st_nxt.state = line_shading_pkg::ST_IDLE;
    endcase
    fifoIn = {inLineStart, pix};
  end

  // State register; restart always begins with the flash restore
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.gain <= {line_shading_pkg::CHANNELS{line_shading_pkg::GAIN_RST}};
      st_r.offset <=
        {line_shading_pkg::CHANNELS{line_shading_pkg::OFFSET_RST}};
      st_r.minPct <= line_shading_pkg::MIN_PCT_RST;
      st_r.tgtPct <= line_shading_pkg::TARGET_PCT_RST;
      st_r.state <= line_shading_pkg::ST_RESTORE_EN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Output buffer toward the image link
  pixel_fifo #(
    .WIDTH(line_shading_pkg::FIFO_W),
    .DEPTH(line_shading_pkg::FIFO_DEPTH)
  ) outFifo (
    .clk(clk),
    .reset(reset),
    .inValid(inValid),
    .inReady(fifoReady),
    .inData(fifoIn),
    .outValid(outValid),
    .outReady(outReady),
    .outData({outLineStart, outData})
  );
endmodule

// >>> tb/flash_model.sv
// Word flash that answers each request after a varying delay.
// Assumes requests are held until the ack pulse.
`timescale 1ns/1ps
module flash_model (
  input wire logic clk, // Clock
  input wire logic flashReq, // Request
  input wire logic flashWrite, // Write
  input wire logic [11:0] flashAddr, // Word address
  input wire logic [11:0] flashWData, // Write word
  output logic [11:0] flashRData, // Read word
  output logic flashAck // Done pulse
);
  logic [11:0] mem [0:2048];
  logic [1:0] waitCnt = 2'h0;
  logic slow = 1'b0;

  // Ramp reference, enable word set
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 12'h020 + 12'(i % 256);
    end
    mem[2048] = 12'h001;
  end

  // Prompt and slow answers alternate; data toggles off the ack
  always @(posedge clk) begin
    flashRData <= ~flashRData;
    flashAck <= 1'b0;
    if (flashReq && !flashAck) begin
      if (waitCnt != 2'h0) begin
        waitCnt <= waitCnt - 2'h1;
      end else begin
        if (flashWrite) begin
          mem[flashAddr] <= flashWData;
        end else begin
          flashRData <= mem[flashAddr];
        end
        flashAck <= 1'b1;
        slow <= !slow;
        waitCnt <= slow ? 2'h0 : 2'h3;
      end
    end
  end
endmodule

// >>> tb/line_shading_sva.sv
// Port timing checker of the shading stage.
// Assumes it is bound to line_shading_correction.
`timescale 1ns/1ps
module line_shading_sva (
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic outValid, // Pixel out
  input wire logic outReady, // Sink ready
  input wire logic [11:0] outData, // Pixel
  input wire logic outLineStart, // Line mark
  input wire logic flashReq, // Flash request
  input wire logic flashWrite, // Flash write
  input wire logic [11:0] flashAddr, // Flash address
  input wire logic [11:0] flashWData, // Flash data
  input wire logic flashAck // Flash done
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  AST_APB_WAIT: assert property (psel && penable && !$past(penable)
    |-> !pready ##1 pready) else $error("pready not in 2nd access cycle");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_APB_ERR: assert property (pslverr |-> pready && psel)
    else $error("pslverr outside an answer");
  AST_FL_HOLD: assert property (flashReq && !flashAck |=> flashReq &&
    $stable(flashAddr) && $stable(flashWrite) && $stable(flashWData))
    else $error("flash request changed before ack");
  AST_FL_GAP: assert property (flashAck |=> !flashReq)
    else $error("flash request not dropped after ack");
  AST_FL_FIRST: assert property ($fell(reset) |-> ##[0:2]
    flashReq && !flashWrite && flashAddr == line_shading_pkg::FLASH_EN_ADDR)
    else $error("restart did not read the enable word");
  AST_OUT_HOLD: assert property (outValid && !outReady |=>
    outValid && $stable(outData) && $stable(outLineStart))
    else $error("output pixel changed while stalled");
  AST_RST_QUIET: assert property (disable iff (1'b0)
    reset |=> !pready && !flashReq && !outValid)
    else $error("outputs active after reset");
endmodule

bind line_shading_correction line_shading_sva u_sva (.clk(clk),
  .reset(reset), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .outValid(outValid), .outReady(outReady),
  .outData(outData), .outLineStart(outLineStart), .flashReq(flashReq),
  .flashWrite(flashWrite), .flashAddr(flashAddr),
  .flashWData(flashWData), .flashAck(flashAck));

// >>> tb/line_shading_correction_tb.sv
// Bench of the shading stage: APB host, pixel source and sink.
// Assumes flash_model starts with a ramp reference and enable set.
`timescale 1ns/1ps
module line_shading_correction_tb;
  localparam int TGT = int'(line_shading_pkg::TARGET_PCT_RST) * 255 / 100;
  localparam int MINP = int'(line_shading_pkg::MIN_PCT_RST);
  logic clk, reset, psel, penable, pwrite, pready, pslverr;
  logic inValid, inReady, inLineStart, outValid, outReady, outLineStart;
  logic flashReq, flashWrite, flashAck, en, fv, stall;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [31:0] orng = 32'hA023;
  logic [11:0] inData, outData, flashAddr, flashWData, flashRData;
  logic [2:0] inChannel;
  logic [1:0] ctrl;
  logic [11:0] gain [6];
  logic [11:0] offs [6];
  logic [12:0] expQ [$];
  logic [12:0] seen;
  int failures, samplesChecked, cycles, idx;
  assign seen = {outLineStart, outData};

  line_shading_correction uut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inValid(inValid), .inReady(inReady), .inData(inData),
    .inChannel(inChannel), .inLineStart(inLineStart),
    .outValid(outValid), .outReady(outReady), .outData(outData),
    .outLineStart(outLineStart), .flashReq(flashReq),
    .flashWrite(flashWrite), .flashAddr(flashAddr),
    .flashWData(flashWData), .flashRData(flashRData),
    .flashAck(flashAck));
  flash_model u_flash (.clk(clk), .flashReq(flashReq),
    .flashWrite(flashWrite), .flashAddr(flashAddr),
    .flashWData(flashWData), .flashRData(flashRData),
    .flashAck(flashAck));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // Expected pixel from the bench's own copy of the settings
  function automatic logic [11:0] model(input logic [11:0] d,
      input logic [2:0] ch, input int i);
    int c, full, g, f;
    c = (ctrl[1] || ch >= 3'h6) ? 0 : int'(ch);
    full = ctrl[0] ? 4095 : 255;
    g = (int'(d) * int'(gain[c])) >> 10;
    g = g + int'($signed(offs[c]));
    g = g < 0 ? 0 : (g > full ? full : g);
    if (en && fv && g >= MINP * full / 100) begin
      f = TGT * 4096 / (32 + i % 256); // Factors were made at 8-bit scale
      g = (g * f) >> 12;
      g = g > full ? full : g;
    end
    return 12'(g);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, g);
    samplesChecked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done;
    $display("failures %0d checked %0d", failures, samplesChecked);
    if (failures == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("register", x, r);
  endtask

  // Command, then poll until the sequencer is idle
  task automatic cmd(input logic [31:0] v);
    logic [31:0] r;
    logic e;
    wr(line_shading_pkg::CMD_OFF, v);
    do apb(1'b0, line_shading_pkg::STATUS_OFF, 32'h0, r, e);
    while (r[line_shading_pkg::STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic send(input logic ls);
    logic [11:0] d;
    logic [2:0] ch;
    rnd = xs(rnd);
    d = rnd[11:0] >> rnd[14:12];
    ch = rnd[18:16];
    idx = ls ? 0 : idx + 1;
    inValid <= 1'b1;
    inData <= d;
    inChannel <= ch;
    inLineStart <= ls;
    do @(posedge clk); while (inReady !== 1'b1);
    expQ.push_back({ls, model(d, ch, idx)});
  endtask

  task automatic drain;
    do @(posedge clk); while (expQ.size() != 0);
  endtask

  task automatic line(input int n);
    for (int i = 0; i < n; i++) send(i == 0);
    inValid <= 1'b0;
    drain;
  endtask

  // Sink with random stalls; each result meets its oldest note
  always @(posedge clk) begin
    orng <= xs(orng);
    outReady <= !stall && orng[3];
    if (!reset && outValid === 1'b1 && outReady === 1'b1) begin
      if (expQ.size() == 0) chk("spare pixel", 32'h0, 32'h1);
      else chk("pixel", expQ.pop_front(), seen);
    end
  end

  // Restore and divide take about 60k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      failures++;
      test_done;
    end
  end

  initial begin
    logic [31:0] r;
    logic e;
    {reset, psel, penable, pwrite, inValid, inLineStart} = 6'h20;
    paddr = 8'h00;
    pwdata = 32'h0;
    inData = 12'h000;
    inChannel = 3'h0;
    {en, fv, stall, ctrl} = 5'h00;
    rnd = 32'hA023;
    for (int c = 0; c < 6; c++) begin
      gain[c] = line_shading_pkg::GAIN_RST;
      offs[c] = line_shading_pkg::OFFSET_RST;
    end
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b0, 8'h80, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    rdc(line_shading_pkg::GAIN_BASE + 8'h14, 32'h400);
    rdc(line_shading_pkg::MIN_OFF, 32'h0A);
    rdc(line_shading_pkg::TARGET_OFF, 32'h5A);
    en = 1'b1;
    line(8);
    cmd(32'h0);
    fv = 1'b1;
    rdc(line_shading_pkg::STATUS_OFF, 32'h3);
    for (int c = 0; c < 6; c++) begin
      rnd = xs(rnd);
      gain[c] = 12'h300 + {3'h0, rnd[8:0]};
      offs[c] = {{7{rnd[20]}}, rnd[20:16]};
      wr(line_shading_pkg::GAIN_BASE + 8'(4 * c), {20'h0, gain[c]});
      wr(line_shading_pkg::OFFSET_BASE + 8'(4 * c), {20'h0, offs[c]});
    end
    // Every resolution and coupling mode
    for (int m = 0; m < 4; m++) begin
      ctrl = 2'(m);
      wr(line_shading_pkg::CTRL_OFF, {30'h0, ctrl});
      line(40);
    end
    // Fill the FIFO with the sink stalled
    stall = 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 16; i++) send(i == 0);
    inValid <= 1'b0;
    @(negedge clk);
    chk("room while full", 32'h0, {31'h0, inReady});
    stall = 1'b0;
    drain;
    cmd(32'h2);
    en = 1'b0;
    chk("stored enable", 32'h0, {20'h0, u_flash.mem[2048]});
    rdc(line_shading_pkg::STATUS_OFF, 32'h2);
    line(20);
    cmd(32'h1);
    en = 1'b1;
    chk("stored enable", 32'h1, {20'h0, u_flash.mem[2048]});
    line(20);
    u_flash.mem[7] = 12'h000;
    wr(line_shading_pkg::CMD_OFF, 32'h8);
    cmd(32'h2); // Dropped while the save runs
    chk("saved word", 32'h27, {20'h0, u_flash.mem[7]});
    rdc(line_shading_pkg::STATUS_OFF, 32'h3);
    line(20);
    // Host load is left unfinished: a full line would outrun the budget
    wr(line_shading_pkg::CMD_OFF, 32'h10);
    for (int i = 0; i < 3; i++) wr(line_shading_pkg::LOADDATA_OFF, 32'h40);
    rdc(line_shading_pkg::LOADPTR_OFF, 32'h3);
    rdc(line_shading_pkg::STATUS_OFF, 32'h7);
    test_done;
  end
endmodule
